//--- core/display_field1_image_window.sv
// Purpose : Places and sizes the field 1 display image and feeds pixels to the sink
// Assumes : Frame counters and field flag come from timing logic on the same clock
// Notes   : Field 2 window, blanking registers and FIFO fill are handled elsewhere
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps

// What this block does
// - Positive offset: image line counter set to 1 at blank end plus offset.
// - Negative vertical offset: image line counter set to 1 at blank end minus offset.
// - Image pixels start on line where line counter is 1; blank before.
// - Image pixel counter cleared to zero at start of each image line.
// - Once line counter reached 1, pixels start where frame pixel equals offset.
// - Negative horizontal offset: pixel counter reset at frame width minus offset.
// - Active pixels before the horizontal start show the default value.
// - Bit 31 enables negative vertical offset; ignored in raw mode.
// - Bit 15 enables negative horizontal offset; ignored in raw mode.
// - Horizontal offset in bits 11-0; LSB forced zero outside raw mode.
// - Vertical offset in bits 27-16, in lines from first active line.
// - Pixels stop when pixel counter reaches width; default for rest of line.
// - Lines stop when line counter reaches height; default for rest of field.
// - Image width in bits 11-0; LSB forced zero outside raw mode.
// - Image height in bits 27-16, in lines.
// - Reserved bits read zero; writes to them are ignored.
// - Frame line counter is compared with the field blank end line.
module display_field1_image_window (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire image_window_pkg::frame_timing_t      timing,
  input  wire logic [image_window_pkg::PIXEL_W-1:0] fifo_data,
  input  wire logic                                 fifo_valid,
  output logic                                      fifo_pop,
  output logic      [image_window_pkg::PIXEL_W-1:0] pixel_out,
  output logic                                      pixel_is_image
);

  localparam int W = image_window_pkg::FIELD_W;
  localparam int P = image_window_pkg::PIXEL_W;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [31:0] offset_reg;
  logic [31:0] offset_next;
  logic [31:0] size_reg;
  logic [31:0] size_next;
  logic [31:0] default_reg;
  logic [31:0] default_next;
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        access_done;
  logic        addr_ok;
  logic [31:0] read_word;
  logic [W-1:0] image_line_counter;
  logic [W-1:0] image_pixel_counter;

  // Answer one cycle into the access phase; the write lands on the next edge, while pready is high
  assign access_done = psel && penable && pready_reg;

  always_comb begin
    addr_ok   = 1'b1;
    read_word = 32'h0000_0000;
    if (paddr == image_window_pkg::OFFSET_REG_ADDR) begin
      read_word = offset_reg;
    end else if (paddr == image_window_pkg::SIZE_REG_ADDR) begin
      read_word = size_reg;
    end else if (paddr == image_window_pkg::DEFAULT_REG_ADDR) begin
      read_word = default_reg;
    end else if (paddr == image_window_pkg::CONTROL_REG_ADDR) begin
      read_word = control_reg;
    end else if (paddr == image_window_pkg::STATUS_REG_ADDR) begin
      read_word = {4'h0, image_line_counter, 4'h0, image_pixel_counter};
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_comb begin
    offset_next  = offset_reg;
    size_next    = size_reg;
    default_next = default_reg;
    control_next = control_reg;
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !addr_ok;
    prdata_next  = prdata_reg;
    if (psel && penable && !pready_reg && !pwrite) begin
      prdata_next = read_word;
    end
    if (access_done && pwrite) begin
      // Reserved bits are masked off on the way in so they always read zero
      if (paddr == image_window_pkg::OFFSET_REG_ADDR) begin
        offset_next = pwdata & image_window_pkg::OFFSET_MASK;
      end else if (paddr == image_window_pkg::SIZE_REG_ADDR) begin
        size_next = pwdata & image_window_pkg::SIZE_MASK;
      end else if (paddr == image_window_pkg::DEFAULT_REG_ADDR) begin
        default_next = pwdata & image_window_pkg::DEFAULT_MASK;
      end else if (paddr == image_window_pkg::CONTROL_REG_ADDR) begin
        control_next = pwdata & image_window_pkg::CONTROL_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      offset_reg  <= image_window_pkg::OFFSET_RESET;
      size_reg    <= image_window_pkg::SIZE_RESET;
      default_reg <= image_window_pkg::DEFAULT_RESET;
      control_reg <= image_window_pkg::CONTROL_RESET;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      offset_reg  <= offset_next;
      size_reg    <= size_next;
      default_reg <= default_next;
      control_reg <= control_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  image_window_pkg::window_cfg_t cfg;
  logic         raw_mode;
  logic         enable;
  logic         neg_v;
  logic         neg_h;
  logic [W-1:0] hoff_eff;
  logic [W-1:0] width_eff;

  assign raw_mode = control_reg[image_window_pkg::RAW_BIT];
  assign enable   = control_reg[image_window_pkg::ENABLE_BIT];

  always_comb begin
    cfg.offset_is_negative_v     = offset_reg[image_window_pkg::NEG_V_BIT];
    cfg.field1_vertical_offset   = offset_reg[image_window_pkg::VOFF_LSB +: W];
    cfg.offset_is_negative_h     = offset_reg[image_window_pkg::NEG_H_BIT];
    cfg.field1_horizontal_offset = offset_reg[image_window_pkg::HOFF_LSB +: W];
    cfg.field1_image_height      = size_reg[image_window_pkg::HEIGHT_LSB +: W];
    cfg.field1_image_width       = size_reg[image_window_pkg::WIDTH_LSB +: W];
  end

  // Sign bits mean nothing in raw data mode
  assign neg_v = cfg.offset_is_negative_v && !raw_mode;
  assign neg_h = cfg.offset_is_negative_h && !raw_mode;

  // Stream modes carry pixel pairs, so offset and width stay even
  assign hoff_eff  = raw_mode ? cfg.field1_horizontal_offset
                              : {cfg.field1_horizontal_offset[W-1:1], 1'b0};
  assign width_eff = raw_mode ? cfg.field1_image_width
                              : {cfg.field1_image_width[W-1:1], 1'b0};

  // ---------------------------------------------------------------
  // Window start points
  // ---------------------------------------------------------------
  logic [W-1:0] v_start;
  logic [W-1:0] h_start;
  logic         field_one;
  logic         line_begin;
  logic         v_hit;
  logic         h_hit;

  // A negative offset larger than the blank end line wraps; software avoids it
  assign v_start = neg_v ? timing.field1_blank_end_line - cfg.field1_vertical_offset
                         : timing.field1_blank_end_line + cfg.field1_vertical_offset;
  assign h_start = neg_h ? timing.frame_width - hoff_eff : hoff_eff;

  assign field_one  = enable && !timing.field_two;
  assign line_begin = timing.frame_pixel_counter == h_start;
  assign v_hit      = field_one && (timing.frame_line_counter == v_start) && line_begin;

  // ---------------------------------------------------------------
  // Vertical sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WAIT_START, IN_IMAGE, FIELD_DONE} vstate_t;

  vstate_t vstate_reg;
  vstate_t vstate_next;
  logic    line_load;
  logic    line_inc;

  always_comb begin
    vstate_next = vstate_reg;
    line_load   = 1'b0;
    line_inc    = 1'b0;
    case (vstate_reg)
      WAIT_START: begin
        if (v_hit) begin
          vstate_next = IN_IMAGE;
          line_load   = 1'b1;
        end
      end
      IN_IMAGE: begin
        if (!field_one) begin
          vstate_next = WAIT_START;
        end else if (line_begin) begin
          if (image_line_counter == cfg.field1_image_height) begin
            vstate_next = FIELD_DONE;
          end else begin
            line_inc = 1'b1;
          end
        end
      end
      FIELD_DONE: begin
        if (!field_one) begin
          vstate_next = WAIT_START;
        end
      end
      default: begin
        vstate_next = WAIT_START;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vstate_reg <= WAIT_START;
    end else begin
      vstate_reg <= vstate_next;
    end
  end

  step_counter #(
    .WIDTH (W)
  ) line_counter_inst (
    .clk        (clk),
    .rstn       (rstn),
    .load       (line_load),
    .load_value ({{(W-1){1'b0}}, 1'b1}),
    .inc        (line_inc),
    .count      (image_line_counter)
  );

  // ---------------------------------------------------------------
  // Horizontal sequencing
  // ---------------------------------------------------------------
  logic h_run_reg;
  logic h_run_next;
  logic pix_clear;
  logic pix_inc;
  logic line_ok;
  logic take;

  // A zero height means no image lines at all
  assign line_ok = (vstate_next == IN_IMAGE) && (cfg.field1_image_height != '0);
  assign h_hit   = line_ok && line_begin;

  always_comb begin
    h_run_next = h_run_reg;
    pix_clear  = 1'b0;
    if (!line_ok) begin
      h_run_next = 1'b0;
    end else if (h_hit) begin
      h_run_next = width_eff != '0;
      pix_clear  = 1'b1;
    end else if (h_run_reg && take && (image_pixel_counter + 1'b1 == width_eff)) begin
      h_run_next = 1'b0;
    end
  end

  // An empty FIFO stalls the count so no image pixel is skipped
  assign take    = h_run_reg && fifo_valid && !h_hit;
  assign pix_inc = take;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_run_reg <= 1'b0;
    end else begin
      h_run_reg <= h_run_next;
    end
  end

  step_counter #(
    .WIDTH (W)
  ) pixel_counter_inst (
    .clk        (clk),
    .rstn       (rstn),
    .load       (pix_clear),
    .load_value ({W{1'b0}}),
    .inc        (pix_inc),
    .count      (image_pixel_counter)
  );

  // ---------------------------------------------------------------
  // Pixel output
  // ---------------------------------------------------------------
  logic [P-1:0] pixel_reg;
  logic [P-1:0] pixel_next;
  logic         is_image_reg;
  logic         is_image_next;
  logic         pop_reg;
  logic         pop_next;

  always_comb begin
    pixel_next    = default_reg[P-1:0];
    is_image_next = 1'b0;
    pop_next      = take;
    // A word is consumed on the edge that sees the pop, so it is captured there
    if (pop_reg) begin
      pixel_next    = fifo_data;
      is_image_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pixel_reg    <= '0;
      is_image_reg <= 1'b0;
      pop_reg      <= 1'b0;
    end else begin
      pixel_reg    <= pixel_next;
      is_image_reg <= is_image_next;
      pop_reg      <= pop_next;
    end
  end

  assign pixel_out      = pixel_reg;
  assign pixel_is_image = is_image_reg;
  assign fifo_pop       = pop_reg;

endmodule

//--- core/image_window_pkg.sv
// Purpose : Constants and carrier types for the field 1 display image window
// Assumes : APB register access, 32-bit words, one pixel clock
// Notes   : Register offsets are byte addresses
package image_window_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFFSET_REG_ADDR  = 8'h00;
  localparam logic [7:0] SIZE_REG_ADDR    = 8'h04;
  localparam logic [7:0] DEFAULT_REG_ADDR = 8'h08;
  localparam logic [7:0] CONTROL_REG_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_REG_ADDR  = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int NEG_V_BIT   = 31;
  localparam int VOFF_LSB    = 16;
  localparam int NEG_H_BIT   = 15;
  localparam int HOFF_LSB    = 0;
  localparam int HEIGHT_LSB  = 16;
  localparam int WIDTH_LSB   = 0;
  localparam int FIELD_W     = 12;
  localparam int RAW_BIT     = 0;
  localparam int ENABLE_BIT  = 1;
  localparam int PIXEL_W     = 16;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [31:0] OFFSET_RESET  = 32'h0000_0000;
  localparam logic [31:0] SIZE_RESET    = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] OFFSET_MASK   = 32'h8fff_8fff;
  localparam logic [31:0] SIZE_MASK     = 32'h0fff_0fff;
  localparam logic [31:0] DEFAULT_MASK  = 32'h0000_ffff;
  localparam logic [31:0] CONTROL_MASK  = 32'h0000_0003;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              offset_is_negative_v;
    logic [FIELD_W-1:0] field1_vertical_offset;
    logic              offset_is_negative_h;
    logic [FIELD_W-1:0] field1_horizontal_offset;
    logic [FIELD_W-1:0] field1_image_height;
    logic [FIELD_W-1:0] field1_image_width;
  } window_cfg_t;

  typedef struct packed {
    logic              field_two;
    logic [FIELD_W-1:0] frame_line_counter;
    logic [FIELD_W-1:0] frame_pixel_counter;
    logic [FIELD_W-1:0] frame_width;
    logic [FIELD_W-1:0] field1_blank_end_line;
  } frame_timing_t;

endpackage

//--- core/step_counter.sv
// Purpose : Loadable up counter for image line and pixel counting
// Assumes : Load wins over increment
// Notes   : Count comes straight from a flip-flop
`timescale 1ns/100ps
module step_counter #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             inc,
  output logic      [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  if (WIDTH < 2) begin : g_width_check
    $error("step_counter WIDTH too small");
  end

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (inc) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

//--- verification/display_field1_image_window_bench.sv
// Purpose : Self-checking bench for the field 1 image window
// Assumes : APB slave answers in the second access cycle
// Notes   : Each window test spans one full field 1 and field 2
`timescale 1ns/100ps
module display_field1_image_window_bench;
  typedef struct {
    logic [31:0] off;
    logic [31:0] size;
    logic [11:0] be;
    logic        raw;
    int          cnt;
    int          line;
    int          px;
  } case_t;
  localparam logic [7:0] off_addr  = image_window_pkg::OFFSET_REG_ADDR;
  localparam logic [7:0] size_addr = image_window_pkg::SIZE_REG_ADDR;
  localparam logic [7:0] dflt_addr = image_window_pkg::DEFAULT_REG_ADDR;
  localparam logic [7:0] ctl_addr  = image_window_pkg::CONTROL_REG_ADDR;
  logic                            clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic                            fifo_valid, fifo_pop, pixel_is_image, armed;
  logic [7:0]                      paddr;
  logic [31:0]                     pwdata, prdata, q;
  logic [11:0]                     blank_end, first_line, first_px;
  logic [15:0]                     fifo_data, pixel_out, dflt;
  image_window_pkg::frame_timing_t timing;
  int                              fails, checks_done, imgs, pops, bad_dflt, cycles, seen, bad_pix;
  case_t                           tc [7];

  display_field1_image_window u_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timing(timing), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .pixel_out(pixel_out),
    .pixel_is_image(pixel_is_image)
  );
  video_source u_src (
    .clk(clk), .rstn(rstn), .blank_end(blank_end), .fifo_pop(fifo_pop),
    .timing(timing), .fifo_data(fifo_data), .fifo_valid(fifo_valid)
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] x, input logic [31:0] got);
    checks_done++;
    if (got !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    check(n, x, q);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, timeout and pixel monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Seven tests of two fields each need about 2900 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
    // Source words count up from a fixed seed, so a repeated or skipped word shows
    if (pixel_is_image === 1'b1) begin
      if (pixel_out !== (16'h5a00 ^ 16'(seen))) bad_pix++;
      seen++;
    end
    if (armed && fifo_pop === 1'b1) pops++;
    if (armed && pixel_is_image === 1'b1) begin
      imgs++;
      if (first_line === 12'hfff) begin
        first_line = timing.frame_line_counter;
        first_px   = timing.frame_pixel_counter;
      end
    end else if (armed && pixel_out !== dflt) begin
      bad_dflt++;
    end
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, armed} = '0;
    blank_end = 12'h002;
    rstn      = 1'b0;
    tc = '{'{32'h0001_0004, 32'h0003_0002, 12'h002, 1'b0, 6, 3, 7},
           '{32'h8002_0002, 32'h0002_0004, 12'h004, 1'b0, 8, 2, 5},
           '{32'h0000_8008, 32'h0002_0004, 12'h001, 1'b0, 8, 1, 11},
           '{32'h0000_0005, 32'h0001_0003, 12'h002, 1'b0, 2, 2, 7},
           '{32'h8001_8005, 32'h0002_0003, 12'h003, 1'b1, 6, 4, 8},
           '{32'h0000_0000, 32'h0000_0004, 12'h002, 1'b0, 0, 4095, 4095},
           '{32'h8003_0000, 32'h0001_0002, 12'h003, 1'b0, 2, 0, 3}};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(off_addr, 32'h0, "offset reset");
    rd(size_addr, 32'h0, "size reset");
    apb(1'b1, ctl_addr, 32'h1);
    apb(1'b1, off_addr, 32'hffff_ffff);
    rd(off_addr, 32'h8fff_8fff, "offset fields");
    apb(1'b1, size_addr, 32'hffff_ffff);
    rd(size_addr, 32'h0fff_0fff, "size fields");
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", 32'h1, {31'h0, e});
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      wait (timing.field_two === 1'b1);
      blank_end <= tc[i].be;
      dflt = 16'h0c00 + 16'(i);
      apb(1'b1, size_addr, tc[i].size);
      apb(1'b1, off_addr, tc[i].off);
      apb(1'b1, dflt_addr, {16'h0, dflt});
      apb(1'b1, ctl_addr, {30'h0, 1'b1, tc[i].raw});
      @(negedge timing.field_two);
      {imgs, pops, bad_dflt, bad_pix} = '0;
      {first_line, first_px} = 24'hfff_fff;
      armed = 1'b1;
      @(posedge timing.field_two);
      armed = 1'b0;
      check("image pixels", 32'(tc[i].cnt), 32'(imgs));
      check("pops", 32'(tc[i].cnt), 32'(pops));
      check("image data", 32'h0, 32'(bad_pix));
      check("first line", 32'(tc[i].line), {20'h0, first_line});
      check("first pixel", 32'(tc[i].px), {20'h0, first_px});
      check("default pixels", 32'h0, 32'(bad_dflt));
      $display("window test %0d done", i);
    end
    conclude();
  end
endmodule

//--- verification/video_source.sv
// Purpose : Frame timing and pixel source facing the image window
// Assumes : Small frame; fields alternate every LINES lines
// Notes   : Source never stalls, so stall handling is not reached here
`timescale 1ns/100ps
module video_source #(
  parameter int FW    = 16,
  parameter int LINES = 12
) (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic [11:0]                          blank_end,
  input  wire logic                                 fifo_pop,
  output image_window_pkg::frame_timing_t           timing,
  output logic      [image_window_pkg::PIXEL_W-1:0] fifo_data,
  output logic                                      fifo_valid
);
  logic [11:0] fp_reg, fl_reg;
  logic        f2_reg;
  logic [15:0] idx_reg;
  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {fp_reg, fl_reg, f2_reg, idx_reg} <= '0;
    end else begin
      fp_reg <= (fp_reg == 12'(FW - 1)) ? 12'h000 : fp_reg + 12'h001;
      if (fp_reg == 12'(FW - 1)) begin
        fl_reg <= (fl_reg == 12'(LINES - 1)) ? 12'h000 : fl_reg + 12'h001;
        if (fl_reg == 12'(LINES - 1)) f2_reg <= !f2_reg;
      end
      if (fifo_pop) idx_reg <= idx_reg + 16'h0001;
    end
  end
  assign timing     = '{f2_reg, fl_reg, fp_reg, 12'(FW), blank_end};
  // Each word differs, so a repeated pixel would show
  assign fifo_data  = 16'h5a00 ^ idx_reg;
  assign fifo_valid = 1'b1;
endmodule

//--- verification/window_props.sv
// Purpose : Concurrent checks on the field 1 image window ports
// Assumes : Register settings are shadowed from completed APB writes
// Notes   : Window position checks assume no line wrap inside one image line
`timescale 1ns/100ps
module window_props (
  input wire logic                                 clk,
  input wire logic                                 rstn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [7:0]                           paddr,
  input wire logic [31:0]                          pwdata,
  input wire logic [31:0]                          prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire image_window_pkg::frame_timing_t      timing,
  input wire logic [image_window_pkg::PIXEL_W-1:0] fifo_data,
  input wire logic                                 fifo_valid,
  input wire logic                                 fifo_pop,
  input wire logic [image_window_pkg::PIXEL_W-1:0] pixel_out,
  input wire logic                                 pixel_is_image
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // Shadow of the programmed window
  // ---------------------------------------------------------------
  logic [31:0] off_reg, siz_reg, dfl_reg, ctl_reg;
  logic [11:0] run_reg, lines_reg, hoff, hstart, vstart, wid, hgt;
  logic        raw;
  wire         wr_hit = psel & penable & pready & pwrite;
  always_comb begin
    raw    = ctl_reg[0];
    hoff   = raw ? off_reg[11:0] : {off_reg[11:1], 1'b0};
    wid    = raw ? siz_reg[11:0] : {siz_reg[11:1], 1'b0};
    hgt    = siz_reg[27:16];
    hstart = (off_reg[15] & !raw) ? timing.frame_width - hoff : hoff;
    vstart = (off_reg[31] & !raw) ? timing.field1_blank_end_line - off_reg[27:16]
                                  : timing.field1_blank_end_line + off_reg[27:16];
  end
  // Line count only clears in field 2, so a whole field 1 is seen at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {off_reg, siz_reg, dfl_reg, ctl_reg} <= '0;
      run_reg   <= '0;
      lines_reg <= '0;
    end else begin
      if (wr_hit && paddr == 8'h00) off_reg <= pwdata;
      if (wr_hit && paddr == 8'h04) siz_reg <= pwdata;
      if (wr_hit && paddr == 8'h08) dfl_reg <= pwdata;
      if (wr_hit && paddr == 8'h0c) ctl_reg <= pwdata;
      run_reg   <= pixel_is_image ? run_reg + 12'h001 : 12'h000;
      lines_reg <= timing.field_two ? 12'h000
                 : lines_reg + 12'(pixel_is_image && run_reg == 12'h000);
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_delay: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 8'h10))
    else $error("pslverr does not match address decode");
  a_default_out: assert property (
    !pixel_is_image && $stable(dfl_reg) |-> pixel_out == dfl_reg[15:0])
    else $error("default value not shown outside image");
  a_start_pixel: assert property (
    $rose(pixel_is_image) |-> timing.frame_pixel_counter == hstart + 12'h003)
    else $error("image line starts at wrong pixel");
  a_line_range: assert property (
    pixel_is_image |-> timing.frame_line_counter >= vstart &&
                       timing.frame_line_counter < vstart + hgt)
    else $error("image pixel on a line outside the window");
  a_run_length: assert property ($fell(pixel_is_image) |-> run_reg == wid)
    else $error("image line length differs from width");
  a_field_lines: assert property (
    $rose(timing.field_two) |-> lines_reg == ((ctl_reg[1] && wid != 0) ? hgt : 12'h000))
    else $error("image line count differs from height");
  a_field2_quiet: assert property (
    timing.field_two && $past(timing.field_two, 2) |-> !pixel_is_image)
    else $error("image pixel during field 2");
  a_pop_per_pixel: assert property (pixel_is_image == $past(fifo_pop))
    else $error("pop does not pair with image pixel");
endmodule

bind display_field1_image_window window_props u_props (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timing(timing), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
  .fifo_pop(fifo_pop), .pixel_out(pixel_out), .pixel_is_image(pixel_is_image)
);
